//--- design/aev_pkg.sv
// Shared constants and types of the three-channel process alarm evaluator.
package aev_pkg;
   localparam int CHANNELS       = 3;
   localparam int CLK_PERIOD_NS  = 50;
   localparam int SAMPLE_PERIOD_MS = 100;
   localparam int SAMPLE_CYCLES_DEF = SAMPLE_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SAMPLES_PER_SEC   = 1000 / SAMPLE_PERIOD_MS;

   // Word offsets of the per-channel settings inside the setting memory.
   localparam logic [1:0] FLD_TYPE = 2'h0;
   localparam logic [1:0] FLD_HYS  = 2'h1;
   localparam logic [1:0] FLD_ASP  = 2'h2;
   localparam logic [1:0] FLD_WIN  = 2'h3;

   // Byte addresses on the register bus.
   localparam logic [7:0] ADR_MEM_LAST = 8'h2c;
   localparam logic [7:0] ADR_CTRL     = 8'h40;
   localparam logic [7:0] ADR_ASSIGN   = 8'h44;
   localparam logic [7:0] ADR_SP       = 8'h48;
   localparam logic [7:0] ADR_STATUS   = 8'h4c;

   // Control register bits.
   localparam int CTRL_RELEASE = 0;
   localparam int CTRL_FORCE_SB = 1;

   // Layout of the alarm type setting word.
   localparam int TYP_KIND_LSB = 0;
   localparam int TYP_SB_BIT   = 8;
   localparam int TYP_POL_BIT  = 9;
   localparam int TYP_LAT_LSB  = 10;

   localparam logic [4:0] KIND_OFF     = 5'h00;
   localparam logic [4:0] KIND_PV_HI   = 5'h01;
   localparam logic [4:0] KIND_PV_LO   = 5'h02;
   localparam logic [4:0] KIND_DEV_HI  = 5'h05;
   localparam logic [4:0] KIND_DEV_LO  = 5'h06;
   localparam logic [4:0] KIND_DEV_OUT = 5'h07;
   localparam logic [4:0] KIND_DEV_IN  = 5'h08;
   localparam logic [4:0] KIND_VEL     = 5'h1d;
   localparam logic [4:0] KIND_FAULT   = 5'h1e;
   localparam logic [4:0] KIND_FAIL    = 5'h1f;

   // Reset values of the settings.
   localparam logic [15:0] TYPE_RST = 16'h0003;
   localparam logic [15:0] WIN_RST  = 16'h0003;
   localparam logic [11:0] ASSIGN_RST = 12'h000;

   // Limits of the hysteresis and the velocity window.
   localparam logic signed [15:0] HYS_MIN = -16'sd19999;
   localparam logic signed [15:0] HYS_MAX = 16'sd30000;
   localparam logic [7:0] WIN_MIN_MAX = 8'd99;
   localparam logic [7:0] WIN_SEC_MAX = 8'd59;
   localparam logic [7:0] SEC_PER_MIN = 8'd60;

   // Output source selections.
   localparam logic [1:0] SRC_TYPE  = 2'h0;
   localparam logic [1:0] SRC_NORM  = 2'h1;
   localparam logic [1:0] SRC_LATCH = 2'h2;
   localparam logic [1:0] SRC_BOTH  = 2'h3;

   typedef enum logic [1:0] {SW_IDLE, SW_READ, SW_CAP, SW_EVAL} aev_sweep_type;
endpackage

//--- design/aev_sync.sv
// Two-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
module aev_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } aev_sync_state_type;

   aev_sync_state_type state_ff;
   aev_sync_state_type nxt_state;

   always_comb
   begin
      nxt_state.meta   = async_in;
      nxt_state.stable = state_ff.meta;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign sync_out = state_ff.stable;
endmodule
`default_nettype wire

//--- design/aev_param_mem.sv
// Setting memory: four words per alarm channel with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module aev_param_mem
   import aev_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic [3:0]  addr,
   input  wire logic        we,
   input  wire logic [15:0] wdata,
   output logic      [15:0] rdata
);
   typedef struct packed {
      logic [15:0][15:0] words;
      logic [15:0]       rd;
   } aev_mem_state_type;

   // The reset image is a constant so the asynchronous reset loads no logic output.
   function automatic aev_mem_state_type mem_reset();
      aev_mem_state_type r;
      r = '0;
      for (int i = 0; i < 4 * CHANNELS; i++)
      begin
         if (i[1:0] == FLD_TYPE)
            r.words[i] = TYPE_RST;
         else if (i[1:0] == FLD_WIN)
            r.words[i] = WIN_RST;
      end
      return r;
   endfunction

   localparam aev_mem_state_type MEM_RST = mem_reset();

   aev_mem_state_type state_ff;
   aev_mem_state_type nxt_state;

   always_comb
   begin
      nxt_state    = state_ff;
      nxt_state.rd = state_ff.words[addr];
      if (we)
         nxt_state.words[addr] = wdata;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
         state_ff <= MEM_RST;
      else
         state_ff <= nxt_state;
   end

   assign rdata = state_ff.rd;
endmodule
`default_nettype wire

//--- design/aev_top.sv
// Three-channel process alarm evaluator with a Wishbone register slave.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Three independent channels, each with type, window, hysteresis and setpoint.
// - Kind codes: off, PV high/low, deviation high/low/out/in, velocity, fault, fail.
// - Type word holds latch digit, polarity, stand-by flag and alarm kind.
// - Latch digit 0 means no latch; 1 to 4 select latch behaviours.
// - Disabled and fail kinds ignore latch, polarity and stand-by digits.
// - Velocity alarm skips hysteresis, stand-by and delay.
// - Deviation thresholds are signed offsets from the setpoint.
// - Fault alarm on burnout, converter failure or cold-junction error.
// - Fault alarm is never suppressed by stand-by.
// - System failure forces contact off, ignoring polarity, latch and stand-by.
// - Armed stand-by holds alarm off until condition first disappears.
// - Stand-by arms at power-on, setpoint change, type change, forced command.
// - Latched output of latch 1, 2 and 4 stays on until a release order.
// - Latch 1: release ignored while condition persists.
// - Latch 2: every release turns latched output off.
// - Latch 3: off on release or when condition clears.
// - Latch 4: release during condition turns output off one sample only.
// - One release order from key, contact or bus clears all channels.
// - Contact and lamp can follow normal, latched or both states.
// - Velocity window limited to 00.01 through 99.59 minutes and seconds.
// - Type setting and velocity window reset to 3.
// - Hysteresis limited to -19999 through 30000 display units.
module aev_top
   import aev_pkg::*;
#(
   parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
) (
   input  wire logic        mclk,
   input  wire logic        reset,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic [15:0] pv_value,
   input  wire logic        pv_burnout,
   input  wire logic        pv_adc_fail,
   input  wire logic        cold_junction_comp_err,
   input  wire logic        system_fail,
   input  wire logic        release_key,
   input  wire logic        release_contact,
   output logic      [2:0]  alarm_contact,
   output logic      [2:0]  event_lamp
);
   import aev_pkg::*;

   typedef struct packed {
      logic [20:0]       div;
      logic [3:0]        sec_div;
      logic              sweep_req;
      logic              sec_req;
      logic              sec_act;
      aev_sweep_type     st;
      logic [1:0]        ch;
      logic [1:0]        fld;
      logic [3:0][15:0]  scr;
      logic              bus_ph;
      logic              ack;
      logic [31:0]       dat;
      logic [15:0]       sp;
      logic [11:0]       sel;
      logic              rel_pend;
      logic              rel_act;
      logic [2:0]        cond;
      logic [2:0]        stby;
      logic [2:0]        hold;
      logic [2:0]        lat;
      logic [2:0]        contact;
      logic [2:0]        lamp;
      logic [2:0][12:0]  vel_cnt;
      logic [2:0][15:0]  vel_ref;
      logic              key_d;
      logic              din_d;
   } aev_top_state_type;

   aev_top_state_type state_ff;
   aev_top_state_type nxt_state;

   logic [5:0]  pins_s;
   logic [3:0]  mem_addr;
   logic        mem_we;
   logic [15:0] mem_wdata;
   logic [15:0] mem_rdata;

   aev_sync #(
      .WIDTH (6)
   ) u_sync (
      .mclk     (mclk),
      .reset    (reset),
      .async_in ({release_contact, release_key, system_fail,
                  cold_junction_comp_err, pv_adc_fail, pv_burnout}),
      .sync_out (pins_s)
   );

   aev_param_mem u_mem (
      .mclk  (mclk),
      .reset (reset),
      .addr  (mem_addr),
      .we    (mem_we),
      .wdata (mem_wdata),
      .rdata (mem_rdata)
   );

   function automatic logic signed [19:0] sx(input logic [15:0] v);
      return {{4{v[15]}}, v};
   endfunction

   // Hysteresis of a high-type compare; low-type compares use the mirrored form.
   function automatic logic hys_high(input logic cur, input logic signed [19:0] v,
                                     input logic signed [19:0] th,
                                     input logic signed [19:0] hy);
      return cur ? !(v < th - hy) : (v > th);
   endfunction

   function automatic logic hys_low(input logic cur, input logic signed [19:0] v,
                                    input logic signed [19:0] th,
                                    input logic signed [19:0] hy);
      return cur ? !(v > th + hy) : (v < th);
   endfunction

   // Hysteresis and window writes are clamped so those stored words never hold an illegal value.
   function automatic logic [15:0] clamp_hys(input logic [15:0] v);
      if ($signed(v) < HYS_MIN)
         return HYS_MIN;
      else if ($signed(v) > HYS_MAX)
         return HYS_MAX;
      return v;
   endfunction

   function automatic logic [15:0] clamp_win(input logic [15:0] v);
      logic [7:0] mn;
      logic [7:0] sc;
      mn = (v[15:8] > WIN_MIN_MAX) ? WIN_MIN_MAX : v[15:8];
      sc = (v[7:0] > WIN_SEC_MAX) ? WIN_SEC_MAX : v[7:0];
      if (mn == 8'h00 && sc == 8'h00)
         sc = 8'h01;
      return {mn, sc};
   endfunction

   always_comb
   begin
      logic        acc;
      logic        rel_new;
      logic [2:0]  arm;
      logic [4:0]  kind;
      logic [2:0]  lmode;
      logic        pol;
      logic        sb_on;
      logic        c;
      logic        n;
      logic        l;
      logic        h;
      logic        src;
      logic [1:0]  sel;
      logic [12:0] win;
      logic signed [19:0] pv;
      logic signed [19:0] dev;
      logic signed [19:0] th;
      logic signed [19:0] hy;
      logic signed [19:0] dv;
      acc = 1'b0;
      rel_new = 1'b0;
      arm = 3'h0;
      kind = state_ff.scr[FLD_TYPE][TYP_KIND_LSB +: 5];
      lmode = state_ff.scr[FLD_TYPE][TYP_LAT_LSB +: 3];
      pol = state_ff.scr[FLD_TYPE][TYP_POL_BIT];
      sb_on = state_ff.scr[FLD_TYPE][TYP_SB_BIT];
      c = 1'b0;
      n = 1'b0;
      l = 1'b0;
      h = 1'b0;
      src = 1'b0;
      sel = 2'h0;
      win = 13'h0;
      pv = sx(pv_value);
      dev = sx(pv_value) - sx(state_ff.sp);
      th = sx(state_ff.scr[FLD_ASP]);
      hy = sx(state_ff.scr[FLD_HYS]);
      dv = 20'sh0;
      nxt_state = state_ff;
      mem_addr = {state_ff.ch, state_ff.fld};
      mem_we = 1'b0;
      mem_wdata = wb_dat_i[15:0];
      nxt_state.ack = 1'b0;
      nxt_state.key_d = pins_s[4];
      nxt_state.din_d = pins_s[5];

      // Sampling period and one-second dividers.
      if (state_ff.div >= 21'(SAMPLE_CYCLES - 1))
      begin
         nxt_state.div = 21'h0;
         nxt_state.sweep_req = 1'b1;
         if (state_ff.sec_div == 4'(SAMPLES_PER_SEC - 1))
         begin
            nxt_state.sec_div = 4'h0;
            nxt_state.sec_req = 1'b1;
         end
         else
            nxt_state.sec_div = state_ff.sec_div + 4'h1;
      end
      else
         nxt_state.div = state_ff.div + 21'h1;

      // Bus slave: accept, then answer one cycle later.
      if (state_ff.bus_ph)
      begin
         nxt_state.bus_ph = 1'b0;
         nxt_state.ack = 1'b1;
         if (wb_we_i)
            nxt_state.dat = 32'h0;
         else if (wb_adr_i <= ADR_MEM_LAST && wb_adr_i[1:0] == 2'h0)
            nxt_state.dat = {16'h0, mem_rdata};
         else if (wb_adr_i == ADR_ASSIGN)
            nxt_state.dat = {20'h0, state_ff.sel};
         else if (wb_adr_i == ADR_SP)
            nxt_state.dat = {16'h0, state_ff.sp};
         else if (wb_adr_i == ADR_STATUS)
            nxt_state.dat = {16'h0, pins_s[3], state_ff.lamp, state_ff.contact,
                             state_ff.lat, state_ff.stby, state_ff.cond};
         else
            nxt_state.dat = 32'h0;
      end
      else if (wb_cyc_i && wb_stb_i && !state_ff.ack && state_ff.st == SW_IDLE)
      begin
         acc = 1'b1;
         nxt_state.bus_ph = 1'b1;
      end

      if (acc && wb_adr_i <= ADR_MEM_LAST && wb_adr_i[1:0] == 2'h0)
      begin
         mem_addr = wb_adr_i[5:2];
         if (wb_we_i && wb_sel_i[1:0] == 2'h3)
         begin
            mem_we = 1'b1;
            if (wb_adr_i[3:2] == FLD_HYS)
               mem_wdata = clamp_hys(wb_dat_i[15:0]);
            else if (wb_adr_i[3:2] == FLD_WIN)
               mem_wdata = clamp_win(wb_dat_i[15:0]);
            if (wb_adr_i[3:2] == FLD_TYPE)
               arm[wb_adr_i[5:4]] = 1'b1;
         end
      end
      else if (acc && wb_we_i)
      begin
         if (wb_adr_i == ADR_CTRL && wb_sel_i[0])
         begin
            rel_new = wb_dat_i[CTRL_RELEASE];
            if (wb_dat_i[CTRL_FORCE_SB])
               arm = 3'h7;
         end
         else if (wb_adr_i == ADR_ASSIGN && wb_sel_i[1:0] == 2'h3)
            nxt_state.sel = wb_dat_i[11:0];
         else if (wb_adr_i == ADR_SP && wb_sel_i[1:0] == 2'h3)
         begin
            nxt_state.sp = wb_dat_i[15:0];
            arm = 3'h7;
         end
      end

      // Rising edges of the key and contact input are release orders.
      if ((pins_s[4] && !state_ff.key_d) || (pins_s[5] && !state_ff.din_d))
         rel_new = 1'b1;

      // Sweep: read four setting words per channel, then evaluate it.
      case (state_ff.st)
         SW_IDLE:
         begin
            if (state_ff.sweep_req && !state_ff.bus_ph && !acc)
            begin
               nxt_state.sweep_req = 1'b0;
               nxt_state.sec_act = state_ff.sec_req;
               nxt_state.sec_req = 1'b0;
               nxt_state.rel_act = state_ff.rel_pend;
               nxt_state.rel_pend = 1'b0;
               nxt_state.ch = 2'h0;
               nxt_state.fld = 2'h0;
               nxt_state.st = SW_READ;
            end
         end
         SW_READ:
            nxt_state.st = SW_CAP;
         SW_CAP:
         begin
            nxt_state.scr[state_ff.fld] = mem_rdata;
            nxt_state.fld = state_ff.fld + 2'h1;
            nxt_state.st = (state_ff.fld == FLD_WIN) ? SW_EVAL : SW_READ;
         end
         default:
         begin
            c = state_ff.cond[state_ff.ch];
            case (kind)
               KIND_PV_HI:
                  c = hys_high(c, pv, th, hy);
               KIND_PV_LO:
                  c = hys_low(c, pv, th, hy);
               KIND_DEV_HI:
                  c = hys_high(c, dev, th, hy);
               KIND_DEV_LO:
                  c = hys_low(c, dev, th, hy);
               KIND_DEV_OUT:
                  c = hys_high(c, dev, th, hy) | hys_low(c, dev, -th, hy);
               KIND_DEV_IN:
                  c = c ? (dev <= th + hy && dev >= -th - hy) : (dev <= th && dev >= -th);
               KIND_VEL:
               begin
                  // The compare only happens at the end of each window.
                  win = 13'(state_ff.scr[FLD_WIN][15:8]) * 13'(SEC_PER_MIN)
                        + 13'(state_ff.scr[FLD_WIN][7:0]);
                  if (state_ff.sec_act)
                  begin
                     nxt_state.vel_cnt[state_ff.ch] = state_ff.vel_cnt[state_ff.ch] + 13'h1;
                     if (state_ff.vel_cnt[state_ff.ch] + 13'h1 >= win)
                     begin
                        dv = pv - sx(state_ff.vel_ref[state_ff.ch]);
                        c = (dv > th) || (-dv > th);
                        nxt_state.vel_ref[state_ff.ch] = pv_value;
                        nxt_state.vel_cnt[state_ff.ch] = 13'h0;
                     end
                  end
               end
               KIND_FAULT:
                  c = pins_s[0] | pins_s[1] | pins_s[2];
               KIND_FAIL:
                  c = pins_s[3];
               default:
                  c = 1'b0;
            endcase
            if (kind == KIND_VEL || kind == KIND_FAULT)
               sb_on = 1'b0;
            n = c && !(sb_on && state_ff.stby[state_ff.ch]);
            if (!c)
               nxt_state.stby[state_ff.ch] = 1'b0;
            nxt_state.cond[state_ff.ch] = c;
            l = state_ff.lat[state_ff.ch];
            h = state_ff.hold[state_ff.ch] && c;
            case (lmode)
               3'h1:
                  l = (state_ff.rel_act && !n) ? 1'b0 : (l | n);
               3'h2:
               begin
                  if (state_ff.rel_act)
                     h = 1'b1;
                  l = state_ff.rel_act ? 1'b0 : (l | (n & !h));
               end
               3'h3:
               begin
                  if (state_ff.rel_act)
                     h = 1'b1;
                  l = n & !h;
               end
               3'h4:
                  l = state_ff.rel_act ? 1'b0 : (l | n);
               default:
               begin
                  lmode = 3'h0;
                  l = n;
               end
            endcase
            nxt_state.lat[state_ff.ch] = l;
            nxt_state.hold[state_ff.ch] = h;
            sel = state_ff.sel[state_ff.ch * 4 +: 2];
            if (sel == SRC_TYPE)
               src = (lmode != 3'h0) ? l : n;
            else if (sel == SRC_NORM)
               src = n;
            else if (sel == SRC_LATCH)
               src = l;
            else
               src = n | l;
            if (kind == KIND_FAIL)
            begin
               nxt_state.contact[state_ff.ch] = !c;
               nxt_state.lamp[state_ff.ch] = c;
            end
            else if (kind == KIND_OFF || c == 1'b0 && l == 1'b0 && src == 1'b0
                     && !(kind inside {KIND_PV_HI, KIND_PV_LO, KIND_DEV_HI, KIND_DEV_LO,
                                       KIND_DEV_OUT, KIND_DEV_IN, KIND_VEL, KIND_FAULT}))
            begin
               nxt_state.contact[state_ff.ch] = 1'b0;
               nxt_state.lamp[state_ff.ch] = 1'b0;
            end
            else
            begin
               nxt_state.contact[state_ff.ch] = src ^ pol;
               nxt_state.lamp[state_ff.ch] = src;
            end
            nxt_state.fld = 2'h0;
            if (state_ff.ch == 2'(CHANNELS - 1))
            begin
               nxt_state.st = SW_IDLE;
               nxt_state.rel_act = 1'b0;
            end
            else
            begin
               nxt_state.ch = state_ff.ch + 2'h1;
               nxt_state.st = SW_READ;
            end
         end
      endcase

      // New orders win over the clears made above in the same cycle.
      if (rel_new)
         nxt_state.rel_pend = 1'b1;
      nxt_state.stby = nxt_state.stby | arm;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state_ff <= '0;
         state_ff.stby <= 3'h7;
         state_ff.sel <= ASSIGN_RST;
      end
      else
         state_ff <= nxt_state;
   end

   assign wb_dat_o = state_ff.dat;
   assign wb_ack_o = state_ff.ack;
   assign alarm_contact = state_ff.contact;
   assign event_lamp = state_ff.lamp;
endmodule
`default_nettype wire

//--- test/aev_checker.sv
// Assertions on the bus and output pins of the alarm evaluator.
`timescale 1ns/1ps
`default_nettype none
module aev_checker
   import aev_pkg::*;
(
   input wire logic        mclk,
   input wire logic        reset,
   input wire logic [7:0]  wb_adr_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic [2:0]  alarm_contact,
   input wire logic [2:0]  event_lamp
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   sequence req_s;
      $rose(wb_cyc_i && wb_stb_i);
   endsequence
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   chk_ack_in_cycle: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i) else $error("stray ack");
   chk_ack_needs_cyc: assert property (!wb_cyc_i |=> !wb_ack_o) else $error("ack without cycle");
   chk_ack_bounded: assert property (req_s |-> ##[1:40] wb_ack_o) else $error("no ack");
   chk_write_data_zero: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
      else $error("write returned data");
   chk_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
      else $error("upper read bits set");
   chk_hole_reads_zero: assert property (wb_ack_o && (wb_adr_i == 8'h30 || wb_adr_i == ADR_CTRL)
      |-> wb_dat_o == 32'h0) else $error("hole read not zero");
   chk_reset_quiet: assert property ($fell(reset) |-> alarm_contact == 3'h0 ##1
      event_lamp == 3'h0) else $error("outputs active after reset");
endmodule
bind aev_top aev_checker u_chk (.mclk(mclk), .reset(reset), .wb_adr_i(wb_adr_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .alarm_contact(alarm_contact), .event_lamp(event_lamp));
`default_nettype wire

//--- test/aev_relay_model.sv
// Behavioural relay contacts and event lamps at the evaluator's outputs.
`timescale 1ns/1ps
`default_nettype none
module aev_relay_model #(
   parameter bit SLOW = 1'b1
) (
   input  wire logic       mclk,
   input  wire logic [2:0] coil,
   input  wire logic [2:0] lamp_drive,
   output logic      [2:0] closed,
   output logic      [2:0] lit
);
   // Armature travel lags the coil by two cycles, so the bench cannot lean on instant contacts.
   typedef struct packed {logic [2:0] a; logic [2:0] b;} aev_rly_type;
   aev_rly_type st_ff;
   aev_rly_type nxt_st;
   always_comb
   begin
      nxt_st.a = coil;
      nxt_st.b = st_ff.a;
   end
   always_ff @(posedge mclk)
      st_ff <= nxt_st;
   assign closed = SLOW ? st_ff.b : coil;
   assign lit    = lamp_drive;
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking testbench of the three-channel alarm evaluator.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import aev_pkg::*;
   localparam int          SC = 40;
   localparam logic [15:0] HI = 16'h0064;
   localparam logic [15:0] LO = 16'hff9c;
   logic        mclk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        key = 1'b0, cont = 1'b0, ack;
   logic [3:0]  sel = 4'h0, pins = 4'h0;
   logic [7:0]  adr = 8'h00;
   logic [15:0] pv = 16'h0000;
   logic [31:0] dat = 32'h0, dat_o, rd;
   logic [2:0]  contact, lamp, closed, lit, hi, lo;
   int          error_cnt = 0, total_checks = 0, cycles = 0, th, hy, sp, v;
   aev_top #(.SAMPLE_CYCLES(SC)) DUT (.mclk(mclk), .reset(reset), .wb_adr_i(adr),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .pv_value(pv), .pv_burnout(pins[0]),
      .pv_adc_fail(pins[1]), .cold_junction_comp_err(pins[2]), .system_fail(pins[3]),
      .release_key(key), .release_contact(cont), .alarm_contact(contact), .event_lamp(lamp));
   aev_relay_model PM (.mclk(mclk), .coil(contact), .lamp_drive(lamp), .closed(closed),
      .lit(lit));
   always #25 mclk = ~mclk;
   always @(posedge mclk)
      if (++cycles == 20000)
      begin
         error_cnt++;
         tally_and_finish;
      end
   task automatic tally_and_finish;
      if (error_cnt == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input int d);
      @(posedge mclk);
      adr <= a;
      we  <= w;
      dat <= d;
      sel <= 4'hf;
      cyc <= 1'b1;
      stb <= 1'b1;
      do @(posedge mclk); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic settle;
      repeat (2 * SC + 10) @(posedge mclk);
   endtask
   function automatic logic nxt_hi(input logic p, input int x, input int t, input int h);
      return x > t ? 1'b1 : (x < t - h ? 1'b0 : p);
   endfunction
   // Applies level and pins, lets a sweep pass, gives at most one order, then checks channel 0.
   task automatic step(input logic [15:0] typ, input logic [15:0] x, input logic [3:0] p,
                       input int act, input logic [1:0] e);
      if (typ != 16'h0)
         wb(8'h00, 1'b1, typ);
      pv   <= x;
      pins <= p;
      settle;
      if (act == 1 || act == 2)
         wb(ADR_CTRL, 1'b1, act);
      key  <= (act == 3);
      cont <= (act == 4);
      repeat (4) @(posedge mclk);
      key  <= 1'b0;
      cont <= 1'b0;
      settle;
      cmp("ch0 lamp,contact", {30'h0, e}, {30'h0, lit[0], closed[0]});
   endtask
   initial
   begin
      void'($urandom(3450));
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      for (int c = 0; c < 3; c++)
      begin
         wb(8'(c * 16), 1'b0, 0);
         cmp("type reset", 32'h3, rd);
         wb(8'(c * 16 + 12), 1'b0, 0);
         cmp("window reset", 32'h3, rd);
      end
      wb(8'h04, 1'b1, 32'h8ad0);
      wb(8'h04, 1'b0, 0);
      cmp("hysteresis clamp", 32'hb1e1, rd);
      wb(8'h0c, 1'b1, 0);
      wb(8'h0c, 1'b0, 0);
      cmp("window floor", 32'h1, rd);
      wb(8'h0c, 1'b1, 32'hffff);
      wb(8'h0c, 1'b0, 0);
      cmp("window ceiling", 32'h633b, rd);
      wb(8'h30, 1'b0, 0);
      wb(ADR_CTRL, 1'b0, 0);
      // Channel 2 watches deviation with its setpoint offset by SP, so all three share th.
      th = int'($urandom_range(400)) - 200;
      hy = int'($urandom_range(40));
      sp = int'($urandom_range(200)) - 100;
      wb(ADR_SP, 1'b1, sp & 32'hffff);
      for (int c = 0; c < 3; c++)
      begin
         wb(8'(c * 16), 1'b1, c == 0 ? 32'h1 : (c == 1 ? 32'h202 : 32'h5));
         wb(8'(c * 16 + 4), 1'b1, hy);
         wb(8'(c * 16 + 8), 1'b1, (c == 2 ? th - sp : th) & 32'hffff);
      end
      // Start far below every threshold so each channel's hysteresis state is known.
      pv <= 16'(th - 200);
      settle;
      hi = 3'h0;
      lo = 3'h1;
      repeat (10)
      begin
         v = th + int'($urandom_range(120)) - 60;
         pv <= 16'(v);
         settle;
         hi[0] = nxt_hi(hi[0], v, th, hy);
         lo[0] = nxt_hi(lo[0], -v, -th, hy);
         cmp("contacts", {29'h0, hi[0], ~lo[0], hi[0]}, {29'h0, contact});
         cmp("lamps", {29'h0, hi[0], lo[0], hi[0]}, {29'h0, lamp});
      end
      wb(8'h04, 1'b1, 0);
      wb(8'h08, 1'b1, 0);
      step(16'h0101, HI, 4'h0, 0, 2'b00);
      step(16'h0000, LO, 4'h0, 0, 2'b00);
      step(16'h0000, HI, 4'h0, 0, 2'b11);
      step(16'h0000, HI, 4'h0, 2, 2'b00);
      step(16'h0801, HI, 4'h0, 0, 2'b11);
      step(16'h0000, HI, 4'h0, 1, 2'b00);
      step(16'h0401, HI, 4'h0, 3, 2'b11);
      step(16'h0000, LO, 4'h0, 0, 2'b11);
      step(16'h0000, LO, 4'h0, 4, 2'b00);
      step(16'h0c01, HI, 4'h0, 0, 2'b11);
      step(16'h0000, LO, 4'h0, 0, 2'b00);
      step(16'h1001, HI, 4'h0, 1, 2'b11);
      step(16'h0201, HI, 4'h0, 0, 2'b10);
      step(16'h011e, 16'h0, 4'h1, 0, 2'b11);
      step(16'h0000, 16'h0, 4'h4, 0, 2'b11);
      step(16'h0000, 16'h0, 4'h0, 0, 2'b00);
      step(16'h1f1f, 16'h0, 4'h0, 0, 2'b01);
      step(16'h0000, 16'h0, 4'h8, 0, 2'b10);
      step(16'h1f00, HI, 4'h0, 0, 2'b00);
      wb(ADR_ASSIGN, 1'b1, 1);
      step(16'h0801, HI, 4'h0, 0, 2'b11);
      step(16'h0000, LO, 4'h0, 0, 2'b00);
      wb(ADR_SP, 1'b1, 0);
      wb(8'h0c, 1'b1, 1);
      step(16'h0006, LO, 4'h0, 0, 2'b11);
      step(16'h0008, 16'h0, 4'h0, 0, 2'b11);
      wb(8'h00, 1'b1, 32'h1d);
      repeat (1400) @(posedge mclk);
      cmp("velocity idle", 32'h0, {31'h0, lamp[0]});
      pv <= HI;
      v = 0;
      repeat (1400) @(posedge mclk) v |= lamp[0];
      cmp("velocity alarm", 32'h1, v);
      tally_and_finish;
   end
endmodule
`default_nettype wire
